// >>> logic/tmt_pkg.sv
// Constants, types and register map of the two-wire master transmitter
// Functional notes
// - Master mode only after START; address picks direction
// - START issued once bus detected free
// - After START set flag, status 08
// - Writing one to flag clears it
// - After address byte set flag, report 18/20/38
// - 18 means acked, 20 means not acked
// - Data write with flag low discarded, collision set
// - In 18/20/28/30 clearing flag sends loaded byte
// - After data byte report 28 or 30
// - STOP sent, then stop bit cleared by hardware
// - In 18/20/28/30 start high sends repeated START
// - Start and stop high: STOP then START
// - After repeated START report 10, keep bus
// - In 10 address-read switches to receive mode
// - Arbitration lost reports 38; start low releases
// - In 38 start high waits free bus, restarts
// - Status codes assume prescaler bits zero
// - Transfer suspended while flag set
package tmt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_DATA    = 4'h4;
  localparam logic [3:0] ADDR_STATUS  = 4'h8;

  // Control bit positions
  localparam int CTL_IRQ_EN    = 0;
  localparam int CTL_ENABLE    = 2;
  localparam int CTL_COLLISION = 3;
  localparam int CTL_STOP      = 4;
  localparam int CTL_START     = 5;
  localparam int CTL_ACK_EN    = 6;
  localparam int CTL_FLAG      = 7;

  // Status codes, prescaler bits zero
  localparam logic [7:0] ST_START    = 8'h08;
  localparam logic [7:0] ST_RESTART  = 8'h10;
  localparam logic [7:0] ST_AW_ACK   = 8'h18;
  localparam logic [7:0] ST_AW_NACK  = 8'h20;
  localparam logic [7:0] ST_D_ACK    = 8'h28;
  localparam logic [7:0] ST_D_NACK   = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_AR_ACK   = 8'h40;
  localparam logic [7:0] ST_AR_NACK  = 8'h48;
  localparam logic [7:0] ST_IDLE     = 8'hF8;
  localparam logic [7:0] ST_MASK     = 8'hF8;
  localparam logic [7:0] CTL_RESET   = 8'h00;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Half bit period in system clocks, minus one
  localparam int HALF_BIT = 50;

  typedef enum logic [3:0] {
    TMT_IDLE, TMT_WAIT_FREE, TMT_START_A, TMT_START_B, TMT_BIT_LOW,
    TMT_BIT_HIGH, TMT_ACK_LOW, TMT_ACK_HIGH, TMT_HOLD, TMT_RS_A,
    TMT_STOP_A, TMT_STOP_B, TMT_STOP_C
  } tmt_state_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } tmt_pins_t;

endpackage : tmt_pkg

// >>> logic/tmt_master.sv
// Two-wire master transmitter with AXI4-Lite register slave
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module tmt_master
  import tmt_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT
) (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // AXI4-Lite write
  input  wire logic [3:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  // AXI4-Lite read
  input  wire logic [3:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // Two-wire bus pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Status
  output logic             irq_o,
  output logic             receive_mode_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       scl_s, sda_s, scl_prev_ff, sda_prev_ff;
  always_ff @(posedge clock_i) begin
    scl_sync_ff <= {scl_sync_ff[0], scl_i};
    sda_sync_ff <= {sda_sync_ff[0], sda_i};
    scl_prev_ff <= scl_sync_ff[1];
    sda_prev_ff <= sda_sync_ff[1];
  end
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];

  // Foreign START/STOP tracking for bus-free detection
  logic busy_ff, nxt_busy;
  wire  ext_start = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  wire  ext_stop  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctl_ff, data_ff, status_ff, shift_ff;
  logic       recv_ff, rx_bit_ff, own_ff;
  tmt_state_t state_ff, nxt_state;
  logic [$clog2(HALF_CYC+1)-1:0] tick_ff;
  logic [3:0] bit_ff;
  tmt_pins_t  pins_ff;

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic       aw_got_ff, w_got_ff, bvalid_ff;
  logic [3:0] aw_addr_ff;
  logic [7:0] wdat_ff;
  logic       wlane_ff;
  wire aw_take = s_awvalid_i & ~aw_got_ff & ~bvalid_ff;
  wire w_take  = s_wvalid_i & ~w_got_ff & ~bvalid_ff;
  wire wr_go   = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_ctl  = wr_go & wlane_ff & (aw_addr_ff == ADDR_CONTROL);
  wire wr_dat  = wr_go & wlane_ff & (aw_addr_ff == ADDR_DATA);
  wire wr_map  = (aw_addr_ff == ADDR_CONTROL) |
                 (aw_addr_ff == ADDR_DATA) | (aw_addr_ff == ADDR_STATUS);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      aw_addr_ff <= 4'h0;
      wdat_ff    <= 8'h00;
      wlane_ff   <= 1'b0;
      s_bresp_o  <= AXI_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_awaddr_i;
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdat_ff  <= s_wdata_i[7:0];
        wlane_ff <= s_wstrb_i[0];
      end
      if (wr_go) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        s_bresp_o <= wr_map ? AXI_OKAY : AXI_SLVERR;
      end else if (bvalid_ff && s_bready_i) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_awready_o = ~aw_got_ff & ~bvalid_ff;
  assign s_wready_o  = ~w_got_ff & ~bvalid_ff;
  assign s_bvalid_o  = bvalid_ff;

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic rvalid_ff;
  wire  ar_take = s_arvalid_i & ~rvalid_ff;
  wire [7:0] rd_sel = (s_araddr_i == ADDR_CONTROL) ? ctl_ff :
                      (s_araddr_i == ADDR_DATA)    ? data_ff :
                      (s_araddr_i == ADDR_STATUS)  ? status_ff : 8'h00;
  wire rd_map = (s_araddr_i == ADDR_CONTROL) |
                (s_araddr_i == ADDR_DATA) | (s_araddr_i == ADDR_STATUS);
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rvalid_ff <= 1'b0;
      s_rdata_o <= 32'h0000_0000;
      s_rresp_o <= AXI_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      s_rdata_o <= {24'h00_0000, rd_sel};
      s_rresp_o <= rd_map ? AXI_OKAY : AXI_SLVERR;
    end else if (rvalid_ff && s_rready_i) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_arready_o = ~rvalid_ff;
  assign s_rvalid_o  = rvalid_ff;

  // ----------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------
  wire flag     = ctl_ff[CTL_FLAG];
  wire enabled  = ctl_ff[CTL_ENABLE];
  wire tick_end = (tick_ff == HALF_CYC[$bits(tick_ff)-1:0]);
  // Writing one to the flag clears it; with the enable bit also written one it releases the engine
  wire go       = wr_ctl & wdat_ff[CTL_FLAG] & wdat_ff[CTL_ENABLE];
  wire set_flag_now;
  logic [7:0] nxt_status;
  logic       nxt_set;
  logic       arb_lost;
  assign arb_lost = (state_ff == TMT_BIT_HIGH) & pins_ff.sda_oe == 1'b0 &
                    shift_ff[7] & ~sda_s & scl_s;

  always_comb begin
    nxt_state  = state_ff;
    nxt_status = status_ff;
    nxt_set    = 1'b0;
    nxt_busy   = busy_ff;
    if (ext_start) nxt_busy = 1'b1;
    if (ext_stop)  nxt_busy = 1'b0;
    case (state_ff)
      TMT_IDLE, TMT_HOLD: begin
        // Suspended until software clears the flag
        if (go && wdat_ff[CTL_START] && wdat_ff[CTL_STOP] && own_ff)
          nxt_state = TMT_STOP_A;
        else if (go && wdat_ff[CTL_STOP] && own_ff)
          nxt_state = TMT_STOP_A;
        else if (go && wdat_ff[CTL_START] && own_ff)
          nxt_state = TMT_RS_A;
        else if (go && wdat_ff[CTL_START])
          nxt_state = TMT_WAIT_FREE;
        else if (go && own_ff && status_ff != ST_ARB_LOST)
          nxt_state = TMT_BIT_LOW;
        else if (go)
          nxt_state = TMT_IDLE;
      end
      TMT_WAIT_FREE:
        if (!busy_ff && scl_s && sda_s && tick_end)
          nxt_state = TMT_START_A;
      TMT_RS_A:
        if (tick_end) nxt_state = TMT_START_A;
      TMT_START_A:
        if (tick_end) nxt_state = TMT_START_B;
      TMT_START_B:
        if (tick_end) begin
          nxt_state  = TMT_HOLD;
          nxt_set    = 1'b1;
          nxt_status = own_ff ? ST_RESTART : ST_START;
        end
      TMT_BIT_LOW:
        if (tick_end) nxt_state = TMT_BIT_HIGH;
      TMT_BIT_HIGH:
        if (arb_lost) begin
          nxt_state  = TMT_IDLE;
          nxt_set    = 1'b1;
          nxt_status = ST_ARB_LOST;
        end else if (tick_end)
          nxt_state = (bit_ff == 4'h7) ? TMT_ACK_LOW : TMT_BIT_LOW;
      TMT_ACK_LOW:
        if (tick_end) nxt_state = TMT_ACK_HIGH;
      TMT_ACK_HIGH:
        if (tick_end) begin
          nxt_state = TMT_HOLD;
          nxt_set   = 1'b1;
          // Address phase after START/restart, data phase otherwise
          if (status_ff == ST_START || status_ff == ST_RESTART) begin
            if (data_ff[0])
              nxt_status = rx_bit_ff ? ST_AR_NACK : ST_AR_ACK;
            else
              nxt_status = rx_bit_ff ? ST_AW_NACK : ST_AW_ACK;
          end else
            nxt_status = rx_bit_ff ? ST_D_NACK : ST_D_ACK;
        end
      TMT_STOP_A:
        if (tick_end) nxt_state = TMT_STOP_B;
      TMT_STOP_B:
        if (tick_end) nxt_state = TMT_STOP_C;
      TMT_STOP_C:
        if (tick_end)
          nxt_state = ctl_ff[CTL_START] ? TMT_WAIT_FREE : TMT_IDLE;
      default: nxt_state = TMT_IDLE;
    endcase
  end
  assign set_flag_now = nxt_set;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff  <= TMT_IDLE;
      status_ff <= ST_IDLE;
      busy_ff   <= 1'b0;
      tick_ff   <= '0;
    end else begin
      state_ff  <= nxt_state;
      status_ff <= nxt_status & ST_MASK;
      busy_ff   <= nxt_busy;
      tick_ff   <= (nxt_state != state_ff || tick_end) ? '0 : tick_ff + 1'b1;
    end
  end

  // SDA moves one clock after SCL falls, so it never races that edge
  wire logic bit_sda_oe = (state_ff == TMT_BIT_HIGH) ? pins_ff.sda_oe :
                          (state_ff == TMT_BIT_LOW)  ? ~shift_ff[7] :
                          ~data_ff[7];
  wire logic ack_sda_oe = (state_ff == TMT_BIT_HIGH) & pins_ff.sda_oe;

  // Shift, bit count, ownership and pin drive
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      shift_ff  <= 8'h00;
      bit_ff    <= 4'h0;
      rx_bit_ff <= 1'b1;
      own_ff    <= 1'b0;
      recv_ff   <= 1'b0;
      pins_ff   <= '0;
    end else begin
      if (state_ff != TMT_BIT_LOW && nxt_state == TMT_BIT_LOW &&
          state_ff != TMT_BIT_HIGH) begin
        shift_ff <= data_ff;
        bit_ff   <= 4'h0;
      end else if (state_ff == TMT_BIT_HIGH && nxt_state == TMT_BIT_LOW) begin
        shift_ff <= {shift_ff[6:0], 1'b0};
        bit_ff   <= bit_ff + 4'h1;
      end
      if (state_ff == TMT_ACK_HIGH && tick_ff == '0)
        rx_bit_ff <= sda_s;
      if (state_ff == TMT_START_B && tick_end)
        own_ff <= 1'b1;
      if (state_ff == TMT_STOP_C || nxt_status == ST_ARB_LOST)
        own_ff <= 1'b0;
      if (nxt_status == ST_AR_ACK || nxt_status == ST_AR_NACK)
        recv_ff <= 1'b1;
      else if (nxt_status == ST_AW_ACK || nxt_status == ST_AW_NACK ||
               state_ff == TMT_STOP_C || nxt_status == ST_ARB_LOST)
        recv_ff <= 1'b0;
      case (nxt_state)
        TMT_START_A:  pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b1};
        TMT_START_B:  pins_ff <= '{scl_oe: 1'b1, sda_oe: 1'b1};
        TMT_RS_A:     pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b0};
        TMT_BIT_LOW:  pins_ff <= '{scl_oe: 1'b1, sda_oe: bit_sda_oe};
        TMT_BIT_HIGH: pins_ff <= '{scl_oe: 1'b0, sda_oe: ~shift_ff[7]};
        TMT_ACK_LOW:  pins_ff <= '{scl_oe: 1'b1, sda_oe: ack_sda_oe};
        TMT_ACK_HIGH: pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b0};
        TMT_HOLD:     pins_ff <= '{scl_oe: own_ff | nxt_set, sda_oe: 1'b0};
        TMT_STOP_A:   pins_ff <= '{scl_oe: 1'b1, sda_oe: 1'b1};
        TMT_STOP_B:   pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b1};
        TMT_STOP_C:   pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b0};
        default:      pins_ff <= '{scl_oe: 1'b0, sda_oe: 1'b0};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctl_ff  <= CTL_RESET;
      data_ff <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_ff[CTL_IRQ_EN] <= wdat_ff[CTL_IRQ_EN];
        ctl_ff[CTL_ENABLE] <= wdat_ff[CTL_ENABLE];
        ctl_ff[CTL_STOP]   <= wdat_ff[CTL_STOP];
        ctl_ff[CTL_START]  <= wdat_ff[CTL_START];
        ctl_ff[CTL_ACK_EN] <= wdat_ff[CTL_ACK_EN];
        if (wdat_ff[CTL_FLAG])
          ctl_ff[CTL_FLAG] <= 1'b0;
      end
      if (set_flag_now)
        ctl_ff[CTL_FLAG] <= 1'b1;
      if (state_ff == TMT_STOP_C && tick_end)
        ctl_ff[CTL_STOP] <= 1'b0;
      if (state_ff == TMT_STOP_C && tick_end && !ctl_ff[CTL_START])
        ctl_ff[CTL_START] <= 1'b0;
      if (nxt_state == TMT_START_B && state_ff == TMT_START_A)
        ctl_ff[CTL_START] <= 1'b0;
      if (!enabled && !wr_ctl)
        ctl_ff[CTL_FLAG] <= ctl_ff[CTL_FLAG];
      if (wr_dat && flag)
        data_ff <= wdat_ff;
      if (wr_dat && !flag)
        ctl_ff[CTL_COLLISION] <= 1'b1;
      else if (wr_dat && flag)
        ctl_ff[CTL_COLLISION] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_o          <= 1'b0;
      receive_mode_o <= 1'b0;
    end else begin
      irq_o          <= ctl_ff[CTL_FLAG] & ctl_ff[CTL_IRQ_EN];
      receive_mode_o <= recv_ff;
    end
  end
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = pins_ff.scl_oe;
  assign sda_oe_o = pins_ff.sda_oe;

endmodule : tmt_master

// >>> bench/tmt_master_sva.sv
// Property checker for the two-wire master transmitter
`timescale 1ns/1ps
module tmt_master_sva
  import tmt_pkg::*;
#(
  parameter int HALF_CYC = HALF_BIT
) (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Register bus
  input wire logic [3:0]  s_awaddr_i,
  input wire logic        s_awvalid_i,
  input wire logic        s_awready_o,
  input wire logic        s_wvalid_i,
  input wire logic        s_wready_o,
  input wire logic [1:0]  s_bresp_o,
  input wire logic        s_bvalid_o,
  input wire logic        s_bready_i,
  input wire logic [3:0]  s_araddr_i,
  input wire logic        s_arvalid_i,
  input wire logic        s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic        s_rvalid_o,
  input wire logic        s_rready_i,
  // Bus pins and status
  input wire logic        scl_i,
  input wire logic        scl_oe_o,
  input wire logic        sda_oe_o,
  input wire logic        irq_o,
  input wire logic        receive_mode_o
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic       aw_bad_ff;
  logic       ar_stat_ff;
  logic [3:0] wr_age_ff;
  wire logic  aw_go = s_awvalid_i & s_awready_o;
  wire logic  w_go = s_wvalid_i & s_wready_o;
  wire logic  ar_go = s_arvalid_i & s_arready_o;
  wire logic  aw_unmapped =
    !(s_awaddr_i inside {ADDR_CONTROL, ADDR_DATA, ADDR_STATUS});
  always_ff @(posedge clock_i) begin
    if (aw_go) aw_bad_ff <= aw_unmapped;
    if (ar_go) ar_stat_ff <= (s_araddr_i == ADDR_STATUS);
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) wr_age_ff <= 4'hF;
    else if (w_go) wr_age_ff <= 4'h0;
    else if (wr_age_ff != 4'hF) wr_age_ff <= wr_age_ff + 4'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SUSPEND: assert property (irq_o && $past(irq_o) |->
    $past(scl_oe_o) == $past(scl_oe_o, 2) &&
    $past(sda_oe_o) == $past(sda_oe_o, 2)) else $error("bus moved");
  AST_FLAG_SCL_LOW: assert property ($rose(irq_o) |-> scl_oe_o)
    else $error("flag set with clock line free");
  AST_START_FREE: assert property ($rose(sda_oe_o) && !scl_oe_o
    |-> scl_i && !$past(scl_oe_o)) else $error("start while clock low");
  AST_SDA_QUIET: assert property ($changed(sda_oe_o) |->
    $stable(scl_oe_o)) else $error("data line moved with clock line");
  AST_FLAG_CLEAR: assert property ($fell(irq_o) |-> wr_age_ff < 4'h7)
    else $error("flag cleared without write");
  AST_RESP_CODE: assert property (s_bvalid_o |->
    s_bresp_o == (aw_bad_ff ? AXI_SLVERR : AXI_OKAY)) else $error("bresp");
  AST_B_HOLD: assert property (s_bvalid_o && !s_bready_i |=>
    s_bvalid_o && $stable(s_bresp_o)) else $error("bvalid dropped");
  AST_R_LAT: assert property (ar_go |=> s_rvalid_o)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_rvalid_o && !s_rready_i |=>
    s_rvalid_o && $stable(s_rdata_o)) else $error("rvalid dropped");
  AST_STATUS_LOW: assert property (s_rvalid_o && ar_stat_ff |->
    s_rdata_o[2:0] == 3'h0 && s_rdata_o[31:8] == 24'h0)
    else $error("status low bits set");
  AST_RX_MODE: assert property ($rose(receive_mode_o) |->
    ##[0:4] irq_o) else $error("receive mode without flag");
  AST_C_FLAG: cover property ($rose(irq_o));
  AST_C_RX: cover property ($rose(receive_mode_o));
  AST_C_ERR: cover property (s_bvalid_o && s_bresp_o == AXI_SLVERR);
endmodule : tmt_master_sva

bind tmt_master tmt_master_sva #(.HALF_CYC(HALF_CYC)) u_sva (
  .clock_i, .rst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wvalid_i,
  .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i,
  .s_arvalid_i, .s_arready_o, .s_rdata_o, .s_rvalid_o, .s_rready_i,
  .scl_i, .scl_oe_o, .sda_oe_o, .irq_o, .receive_mode_o
);

// >>> bench/tmt_slave_model.sv
// Behavioural slave receiver on the two-wire bus
`timescale 1ns/1ps
module tmt_slave_model (
  // Resolved bus levels
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  // Acknowledge choice
  input  wire logic  ack_i,
  // Pull-down and observed traffic
  output logic       sda_oe_o,
  output logic [7:0] byte_o,
  output logic [3:0] nbits_o
);
  logic [7:0] shift_ff;
  initial begin
    sda_oe_o = 1'h0;
    byte_o = 8'h00;
    nbits_o = 4'hF;
    shift_ff = 8'h00;
  end
  // START opens a frame, STOP closes it
  always @(negedge sda_i) if (scl_i === 1'h1) nbits_o = 4'h0;
  always @(posedge sda_i) if (scl_i === 1'h1) nbits_o = 4'hF;
  // Bits taken MSB first on the rising clock
  always @(posedge scl_i) begin
    if (nbits_o < 4'h8) shift_ff = {shift_ff[6:0], sda_i};
    if (nbits_o < 4'h9) nbits_o = nbits_o + 4'h1;
  end
  // Acknowledge in the ninth clock, released after it
  always @(negedge scl_i) begin
    sda_oe_o = (nbits_o == 4'h8) && ack_i;
    if (nbits_o == 4'h9) begin
      byte_o = shift_ff;
      nbits_o = 4'h0;
    end
  end
endmodule : tmt_slave_model

// >>> bench/i2c_master_transmit_fsm_tb_top.sv
// Self-checking bench for the two-wire master transmitter
`timescale 1ns/1ps
module i2c_master_transmit_fsm_tb_top;
  import tmt_pkg::*;
  localparam logic [7:0] T_CTL [11] = '{8'hA5, 8'h85, 8'h85, 8'h85, 8'h85,
    8'hA5, 8'h85, 8'hA5, 8'h85, 8'hB5, 8'h85};
  localparam int T_KIND [11] = '{3, 1, 0, 0, 0, 3, 1, 3, 2, 3, 1};
  localparam logic [10:0] T_ACK = 11'h6F5;
  localparam logic [7:0] T_ST [11] = '{ST_START, ST_AW_NACK, ST_D_ACK,
    ST_D_NACK, ST_D_ACK, ST_RESTART, ST_AW_ACK, ST_RESTART, ST_AR_NACK,
    ST_START, ST_AW_ACK};
  logic        clock_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, slv_ack = 1'h1;
  logic [31:0] wdata = 32'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, rx_mode;
  logic        scl_oe, sda_oe, slv_oe;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  slv_byte;
  logic [3:0]  slv_bits;
  wire logic   scl_w = !scl_oe;
  wire logic   sda_w = !(sda_oe || slv_oe);
  int          bad_count = 0;
  int          check_count = 0;
  logic [31:0] exp_b [$];
  logic [31:0] exp_r [$];
  logic [15:0] lfsr = 16'hF134;

  initial forever #12.5 clock_i = ~clock_i;

  tmt_master #(.HALF_CYC(3)) DUT (
    .clock_i(clock_i), .rst_i(rst_i), .s_awaddr_i(awaddr),
    .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
    .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq),
    .receive_mode_o(rx_mode));

  tmt_slave_model SLV (.scl_i(scl_w), .sda_i(sda_w), .ack_i(slv_ack),
    .sda_oe_o(slv_oe), .byte_o(slv_byte), .nbits_o(slv_bits));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (bad_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic tick(inout int n);
    @(posedge clock_i);
    n++;
    if (n > 3000) begin
      bad_count++;
      conclude();
    end
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    int n;
    n = 0;
    exp_b.push_back({30'h0, r});
    @(posedge clock_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      tick(n);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!(bvalid && bready));
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    int n;
    n = 0;
    exp_r.push_back({24'h0, e});
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      tick(n);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!(rvalid && rready));
    rready <= 1'h0;
  endtask : rd

  task automatic wait_flag();
    int n;
    n = 0;
    while (irq !== 1'h0) tick(n);
    while (irq !== 1'h1) tick(n);
  endtask : wait_flag

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  // ----------------------------------------------------------------
  // Response monitor
  // ----------------------------------------------------------------
  always @(posedge clock_i) begin
    if (bvalid && bready) check({30'h0, bresp}, exp_b.pop_front());
    if (rvalid && rready) check(rdata, exp_r.pop_front());
    if (rvalid && rready) check({30'h0, rresp}, {30'h0, AXI_OKAY});
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [7:0] b;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'h0;
    rd(ADDR_CONTROL, CTL_RESET);
    rd(ADDR_STATUS, ST_IDLE);
    wr(ADDR_DATA, 8'h55, 4'hF, AXI_OKAY);
    wr(ADDR_CONTROL, 8'hA5, 4'h0, AXI_OKAY);
    rd(ADDR_CONTROL, 8'h08);
    wr(4'hC, 8'hA5, 4'hF, AXI_SLVERR);
    rd(ADDR_STATUS, ST_IDLE);
    for (int i = 0; i < 11; i++) begin
      lfsr = lfsr_next(lfsr);
      b = (T_KIND[i] == 0) ? lfsr[7:0] : {lfsr[7:1], T_KIND[i] == 2};
      slv_ack <= T_ACK[i];
      if (T_KIND[i] != 3) wr(ADDR_DATA, b, 4'hF, AXI_OKAY);
      wr(ADDR_CONTROL, T_CTL[i], 4'hF, AXI_OKAY);
      wait_flag();
      rd(ADDR_STATUS, T_ST[i]);
      if (T_KIND[i] != 3) check({24'h0, slv_byte}, {24'h0, b});
      if (T_KIND[i] == 2) check({31'h0, rx_mode}, 32'h1);
    end
    wr(ADDR_CONTROL, 8'h95, 4'hF, AXI_OKAY);
    n = 0;
    while (scl_oe !== 1'h0 || sda_oe !== 1'h0) tick(n);
    repeat (8) @(posedge clock_i);
    rd(ADDR_CONTROL, 8'h05);
    check({25'h0, irq, sda_w, scl_w, slv_bits}, 32'h3F);
    @(posedge clock_i);
    conclude();
  end
endmodule : i2c_master_transmit_fsm_tb_top
